//--- hw/ftm_glitch_filter.sv
// Tach input glitch filter sampled on the slow reference tick
`default_nettype none
module ftm_glitch_filter (
  input  wire logic clk_i,
  input  wire logic rstn_i,
  input  wire logic run_i,
  input  wire logic tick_i,
  input  wire logic filter_en_i,
  input  wire logic pin_i,
  output logic      level_o
);
  logic samp_q;
  logic samp_d;
  logic level_q;
  logic level_d;

  always_comb
  begin
    samp_d  = samp_q;
    level_d = level_q;
    if (run_i)
    begin
      if (!filter_en_i)
      begin
        samp_d  = pin_i;
        level_d = pin_i;
      end
      else if (tick_i)
      begin
        samp_d = pin_i;
        // Needs two equal samples in a row, so a pulse shorter than one tick never passes
        if (pin_i == samp_q)
          level_d = pin_i;
      end
    end
  end

  always_ff @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      samp_q  <= 1'b0;
      level_q <= 1'b0;
    end
    else
    begin
      samp_q  <= samp_d;
      level_q <= level_d;
    end
  end

  assign level_o = level_q;
endmodule
`default_nettype wire

//--- hw/ftm_pkg.sv
// Shared constants, types and helpers of the fan tach monitor
`default_nettype none
package ftm_pkg;
  // Timing: system clock and the slow reference that the monitor counts
  localparam int unsigned CLK_PERIOD_NS = 100;
  localparam int unsigned REF_PERIOD_NS = 10000;
  localparam int unsigned REF_DIV       = (REF_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned DIV_W         = $clog2(REF_DIV);
  localparam logic [DIV_W-1:0] REF_DIV_LAST = DIV_W'(REF_DIV - 1);

  // Register byte offsets
  localparam int unsigned ADDR_W     = 5;
  localparam logic [ADDR_W-1:0] OFF_CTRL   = 5'h00;
  localparam logic [ADDR_W-1:0] OFF_STATUS = 5'h04;
  localparam logic [ADDR_W-1:0] OFF_HIGH   = 5'h08;
  localparam logic [ADDR_W-1:0] OFF_LOW    = 5'h0c;
  localparam logic [ADDR_W-1:0] OFF_MASK   = 5'h10;

  // Control word layout
  localparam int unsigned CTL_LIMIT_EN   = 0;
  localparam int unsigned CTL_ENABLE     = 1;
  localparam int unsigned CTL_FILTER     = 8;
  localparam int unsigned CTL_MODE       = 10;
  localparam int unsigned CTL_EDGE_LSB   = 11;
  localparam int unsigned CTL_READY_IEN  = 14;
  localparam int unsigned CTL_TOGGLE_IEN = 15;
  localparam int unsigned CNT_LSB        = 16;
  localparam logic [31:0] CTRL_WMASK     = 32'h0000dd03;

  // Status word layout
  localparam int unsigned ST_W       = 4;
  localparam int unsigned ST_LIMIT   = 0;
  localparam int unsigned ST_PIN     = 1;
  localparam int unsigned ST_TOGGLE  = 2;
  localparam int unsigned ST_READY   = 3;
  localparam logic [ST_W-1:0] ST_STICKY  = 4'hd;
  localparam logic [ST_W-1:0] MASK_RESET = 4'hd;

  localparam int unsigned CNT_W = 16;
  localparam logic [CNT_W-1:0] CNT_MAX    = 16'hffff;
  localparam logic [CNT_W-1:0] CNT_ONE    = 16'h0001;
  localparam logic [CNT_W-1:0] HIGH_RESET = 16'hffff;
  localparam logic [CNT_W-1:0] LOW_RESET  = 16'h0000;

  // Edge count select codes and the edge counts they stand for
  localparam int unsigned EDGE_W = 4;
  localparam logic [1:0] EDGE_SEL_9 = 2'h3;
  localparam logic [1:0] EDGE_SEL_5 = 2'h2;
  localparam logic [1:0] EDGE_SEL_3 = 2'h1;
  localparam logic [EDGE_W-1:0] EDGES_9 = 4'h9;
  localparam logic [EDGE_W-1:0] EDGES_5 = 4'h5;
  localparam logic [EDGE_W-1:0] EDGES_3 = 4'h3;
  localparam logic [EDGE_W-1:0] EDGES_2 = 4'h2;
  localparam logic [EDGE_W-1:0] EDGE_ONE = 4'h1;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef struct packed {
    logic       toggle_ien;
    logic       ready_ien;
    logic [1:0] edge_sel;
    logic       mode;
    logic       filter_en;
    logic       enable;
    logic       limit_en;
  } ftm_ctrl_type;

  localparam ftm_ctrl_type CTRL_RESET = '0;

  typedef enum logic [1:0] {
    MEAS_WAIT  = 2'b01,
    MEAS_COUNT = 2'b10
  } ftm_meas_type;

  function automatic logic [31:0] ftm_ctrl_to_word(input ftm_ctrl_type c);
    logic [31:0] w;
    w                   = '0;
    w[CTL_LIMIT_EN]     = c.limit_en;
    w[CTL_ENABLE]       = c.enable;
    w[CTL_FILTER]       = c.filter_en;
    w[CTL_MODE]         = c.mode;
    w[CTL_EDGE_LSB+:2]  = c.edge_sel;
    w[CTL_READY_IEN]    = c.ready_ien;
    w[CTL_TOGGLE_IEN]   = c.toggle_ien;
    return w;
  endfunction

  function automatic ftm_ctrl_type ftm_word_to_ctrl(input logic [31:0] w);
    ftm_ctrl_type c;
    c.limit_en   = w[CTL_LIMIT_EN];
    c.enable     = w[CTL_ENABLE];
    c.filter_en  = w[CTL_FILTER];
    c.mode       = w[CTL_MODE];
    c.edge_sel   = w[CTL_EDGE_LSB+:2];
    c.ready_ien  = w[CTL_READY_IEN];
    c.toggle_ien = w[CTL_TOGGLE_IEN];
    return c;
  endfunction

  function automatic logic [EDGE_W-1:0] ftm_edge_target(input logic [1:0] sel);
    logic [EDGE_W-1:0] n;
    n = EDGES_2;
    if (sel == EDGE_SEL_9)
      n = EDGES_9;
    else if (sel == EDGE_SEL_5)
      n = EDGES_5;
    else if (sel == EDGE_SEL_3)
      n = EDGES_3;
    return n;
  endfunction

  // Byte-lane merge of a write into an old word
  function automatic logic [31:0] ftm_merge(input logic [31:0] old_w, input logic [31:0] new_w,
                                            input logic [3:0] strb);
    logic [31:0] r;
    r = old_w;
    for (int i = 0; i < 4; i++)
      if (strb[i])
        r[8*i+:8] = new_w[8*i+:8];
    return r;
  endfunction
endpackage
`default_nettype wire

//--- hw/ftm_top.sv
// Fan tach monitor: count modes, limit check, interrupt and AXI4-Lite registers
// Function
// - Mode 1 counts reference clock ticks
// - Mode 1 latches, clears after programmed edges
// - Mode 0 counts tach rising edges
// - Filter drops pulses under one tick
// - Enable off freezes block, releases pin
// - Limit interrupt only when enabled
// - Edge select codes give 9/5/3/2
// - Mode 1 latches FFFF when stalled after an edge has started an interval
// - Limit flag on out-of-range, write-one clears
`default_nettype none
module ftm_top (
  input  wire logic        clk_i,
  input  wire logic        rstn_i,
  input  wire logic        fan_pulse_pin_i,
  output logic             pin_input_en_o,
  output logic             irq_o,
  input  wire logic [31:0] s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [31:0] s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready
);
  localparam int unsigned CW = ftm_pkg::CNT_W;

  ftm_pkg::ftm_ctrl_type         ctrl_q,   ctrl_d;
  logic [CW-1:0]                 speed_q,  speed_d;
  logic [CW-1:0]                 cnt_q,    cnt_d;
  logic [CW-1:0]                 high_q,   high_d;
  logic [CW-1:0]                 low_q,    low_d;
  logic [ftm_pkg::ST_W-1:0]      status_q, status_d;
  logic [ftm_pkg::ST_W-1:0]      mask_q,   mask_d;
  logic [ftm_pkg::EDGE_W-1:0]    edges_q,  edges_d;
  ftm_pkg::ftm_meas_type         meas_q,   meas_d;
  logic [ftm_pkg::DIV_W-1:0]     div_q,    div_d;
  logic                          prev_q,   prev_d;
  logic                          irq_q,    irq_d;
  logic                          pin_en_q, pin_en_d;
  logic                          aw_held_q, aw_held_d;
  logic                          w_held_q,  w_held_d;
  logic [ftm_pkg::ADDR_W-1:0]    aw_addr_q, aw_addr_d;
  logic                          aw_bad_q,  aw_bad_d;
  logic [31:0]                   w_data_q,  w_data_d;
  logic [3:0]                    w_strb_q,  w_strb_d;
  logic                          awready_q, awready_d;
  logic                          wready_q,  wready_d;
  logic                          bvalid_q,  bvalid_d;
  logic [1:0]                    bresp_q,   bresp_d;
  logic                          arready_q, arready_d;
  logic                          rvalid_q,  rvalid_d;
  logic [31:0]                   rdata_q,   rdata_d;
  logic [1:0]                    rresp_q,   rresp_d;
  logic                          level;
  logic                          tick;

  // While disabled the divider holds too, which stands in for gating the clocks
  assign tick = ctrl_q.enable && (div_q == ftm_pkg::REF_DIV_LAST);

  ftm_glitch_filter u_filter (
    .clk_i       (clk_i),
    .rstn_i      (rstn_i),
    .run_i       (ctrl_q.enable),
    .tick_i      (tick),
    .filter_en_i (ctrl_q.filter_en),
    .pin_i       (fan_pulse_pin_i),
    .level_o     (level)
  );

  always_comb
  begin
    logic                     run;
    logic                     rise;
    logic                     edge_seen;
    logic                     latch;
    logic [CW-1:0]            latch_val;
    logic [ftm_pkg::ST_W-1:0] set;
    logic [ftm_pkg::ST_W-1:0] clr;
    logic [ftm_pkg::ST_W-1:0] ien;
    logic [31:0]              ctrl_w;
    logic                     wr_go;
    logic                     rd_go;
    logic                     rd_bad;
    logic [ftm_pkg::ADDR_W-1:0] ra;
    logic [31:0]              hi_w;
    logic [31:0]              lo_w;
    run       = ctrl_q.enable;
    rise      = run && level && !prev_q;
    edge_seen = run && (level != prev_q);
    latch     = 1'b0;
    latch_val = speed_q;
    set       = '0;
    clr       = '0;
    ctrl_w    = ftm_pkg::ftm_ctrl_to_word(ctrl_q);
    hi_w      = ftm_pkg::ftm_merge({16'h0000, high_q}, w_data_q, w_strb_q);
    lo_w      = ftm_pkg::ftm_merge({16'h0000, low_q}, w_data_q, w_strb_q);
    ctrl_d    = ctrl_q;
    speed_d   = speed_q;
    cnt_d     = cnt_q;
    high_d    = high_q;
    low_d     = low_q;
    mask_d    = mask_q;
    edges_d   = edges_q;
    meas_d    = meas_q;
    div_d     = div_q;
    prev_d    = run ? level : prev_q;
    pin_en_d  = ctrl_q.enable;

    if (run)
      div_d = tick ? '0 : div_q + 1'b1;

    if (edge_seen)
      set[ftm_pkg::ST_TOGGLE] = 1'b1;

    if (!ctrl_q.mode)
    begin
      if (rise)
      begin
        cnt_d     = cnt_q + ftm_pkg::CNT_ONE;
        latch     = 1'b1;
        latch_val = cnt_q + ftm_pkg::CNT_ONE;
      end
    end
    else
    begin
      if (tick)
        cnt_d = cnt_q + ftm_pkg::CNT_ONE;
      unique case (meas_q)
        ftm_pkg::MEAS_WAIT:
        begin
          if (edge_seen)
          begin
            cnt_d   = '0;
            edges_d = ftm_pkg::EDGE_ONE;
            meas_d  = ftm_pkg::MEAS_COUNT;
          end
        end
        ftm_pkg::MEAS_COUNT:
        begin
          if (edge_seen && (edges_q + ftm_pkg::EDGE_ONE == ftm_pkg::ftm_edge_target(ctrl_q.edge_sel)))
          begin
            latch     = 1'b1;
            latch_val = cnt_q;
            cnt_d     = '0;
            edges_d   = ftm_pkg::EDGE_ONE;  // This edge opens the next interval
          end
          else if (tick && cnt_q == ftm_pkg::CNT_MAX)
          begin
            latch     = 1'b1;
            latch_val = ftm_pkg::CNT_MAX;
            cnt_d     = '0;
            meas_d    = ftm_pkg::MEAS_WAIT;
          end
          else if (edge_seen)
            edges_d = edges_q + ftm_pkg::EDGE_ONE;
        end
      endcase
      if (latch)
        set[ftm_pkg::ST_READY] = 1'b1;
    end

    if (latch)
    begin
      speed_d = latch_val;
      if (latch_val > high_q || latch_val < low_q)
        set[ftm_pkg::ST_LIMIT] = 1'b1;
    end

    // Register writes
    wr_go     = aw_held_q && w_held_q && !bvalid_q;
    aw_held_d = aw_held_q;
    aw_addr_d = aw_addr_q;
    aw_bad_d  = aw_bad_q;
    w_held_d  = w_held_q;
    w_data_d  = w_data_q;
    w_strb_d  = w_strb_q;
    bvalid_d  = bvalid_q;
    bresp_d   = bresp_q;
    if (s_axi_awvalid && awready_q)
    begin
      aw_held_d = 1'b1;
      aw_addr_d = s_axi_awaddr[ftm_pkg::ADDR_W-1:0];
      aw_bad_d  = |s_axi_awaddr[31:ftm_pkg::ADDR_W];
    end
    if (s_axi_wvalid && wready_q)
    begin
      w_held_d = 1'b1;
      w_data_d = s_axi_wdata;
      w_strb_d = s_axi_wstrb;
    end
    if (bvalid_q && s_axi_bready)
      bvalid_d = 1'b0;
    if (wr_go)
    begin
      aw_held_d = 1'b0;
      w_held_d  = 1'b0;
      bvalid_d  = 1'b1;
      bresp_d   = ftm_pkg::RESP_OKAY;
      if (aw_bad_q)
        bresp_d = ftm_pkg::RESP_SLVERR;
      else if (aw_addr_q == ftm_pkg::OFF_CTRL)
        ctrl_d = ftm_pkg::ftm_word_to_ctrl(ftm_pkg::ftm_merge(ctrl_w, w_data_q, w_strb_q)
                                           & ftm_pkg::CTRL_WMASK);
      else if (aw_addr_q == ftm_pkg::OFF_STATUS)
      begin
        if (w_strb_q[0])
          clr = w_data_q[ftm_pkg::ST_W-1:0] & ftm_pkg::ST_STICKY;
      end
      else if (aw_addr_q == ftm_pkg::OFF_HIGH)
        high_d = hi_w[CW-1:0];
      else if (aw_addr_q == ftm_pkg::OFF_LOW)
        low_d = lo_w[CW-1:0];
      else if (aw_addr_q == ftm_pkg::OFF_MASK)
      begin
        if (w_strb_q[0])
          mask_d = w_data_q[ftm_pkg::ST_W-1:0] & ftm_pkg::ST_STICKY;
      end
      else
        bresp_d = ftm_pkg::RESP_SLVERR;
    end
    awready_d = !aw_held_d && !bvalid_d;
    wready_d  = !w_held_d && !bvalid_d;

    // Register reads; a status read also clears the sticky bits it returned
    rd_go    = s_axi_arvalid && arready_q;
    ra       = s_axi_araddr[ftm_pkg::ADDR_W-1:0];
    rd_bad   = |s_axi_araddr[31:ftm_pkg::ADDR_W];
    rvalid_d = rvalid_q;
    rdata_d  = rdata_q;
    rresp_d  = rresp_q;
    if (rvalid_q && s_axi_rready)
      rvalid_d = 1'b0;
    if (rd_go)
    begin
      rvalid_d = 1'b1;
      rresp_d  = ftm_pkg::RESP_OKAY;
      rdata_d  = '0;
      if (rd_bad)
        rresp_d = ftm_pkg::RESP_SLVERR;
      else if (ra == ftm_pkg::OFF_CTRL)
        rdata_d = {speed_q, ctrl_w[ftm_pkg::CNT_LSB-1:0]};
      else if (ra == ftm_pkg::OFF_STATUS)
      begin
        rdata_d[ftm_pkg::ST_W-1:0] = status_q;
        clr = clr | (status_q & ftm_pkg::ST_STICKY);
      end
      else if (ra == ftm_pkg::OFF_HIGH)
        rdata_d[CW-1:0] = high_q;
      else if (ra == ftm_pkg::OFF_LOW)
        rdata_d[CW-1:0] = low_q;
      else if (ra == ftm_pkg::OFF_MASK)
        rdata_d[ftm_pkg::ST_W-1:0] = mask_q;
      else
        rresp_d = ftm_pkg::RESP_SLVERR;
    end
    arready_d = !rvalid_d;

    // A set in the same cycle as a clear wins
    status_d                  = ((status_q & ~clr) | set) & ftm_pkg::ST_STICKY;
    status_d[ftm_pkg::ST_PIN] = level;
    ien                       = '0;
    ien[ftm_pkg::ST_LIMIT]    = ctrl_d.limit_en;
    ien[ftm_pkg::ST_TOGGLE]   = ctrl_d.toggle_ien;
    ien[ftm_pkg::ST_READY]    = ctrl_d.ready_ien;
    irq_d                     = |(status_d & mask_d & ien);
  end

  always_ff @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      ctrl_q    <= ftm_pkg::CTRL_RESET;
      speed_q   <= '0;
      cnt_q     <= '0;
      high_q    <= ftm_pkg::HIGH_RESET;
      low_q     <= ftm_pkg::LOW_RESET;
      status_q  <= '0;
      mask_q    <= ftm_pkg::MASK_RESET;
      edges_q   <= '0;
      meas_q    <= ftm_pkg::MEAS_WAIT;
      div_q     <= '0;
      prev_q    <= 1'b0;
      irq_q     <= 1'b0;
      pin_en_q  <= 1'b0;
      aw_held_q <= 1'b0;
      aw_addr_q <= '0;
      aw_bad_q  <= 1'b0;
      w_held_q  <= 1'b0;
      w_data_q  <= '0;
      w_strb_q  <= '0;
      awready_q <= 1'b0;
      wready_q  <= 1'b0;
      bvalid_q  <= 1'b0;
      bresp_q   <= ftm_pkg::RESP_OKAY;
      arready_q <= 1'b0;
      rvalid_q  <= 1'b0;
      rdata_q   <= '0;
      rresp_q   <= ftm_pkg::RESP_OKAY;
    end
    else
    begin
      ctrl_q    <= ctrl_d;
      speed_q   <= speed_d;
      cnt_q     <= cnt_d;
      high_q    <= high_d;
      low_q     <= low_d;
      status_q  <= status_d;
      mask_q    <= mask_d;
      edges_q   <= edges_d;
      meas_q    <= meas_d;
      div_q     <= div_d;
      prev_q    <= prev_d;
      irq_q     <= irq_d;
      pin_en_q  <= pin_en_d;
      aw_held_q <= aw_held_d;
      aw_addr_q <= aw_addr_d;
      aw_bad_q  <= aw_bad_d;
      w_held_q  <= w_held_d;
      w_data_q  <= w_data_d;
      w_strb_q  <= w_strb_d;
      awready_q <= awready_d;
      wready_q  <= wready_d;
      bvalid_q  <= bvalid_d;
      bresp_q   <= bresp_d;
      arready_q <= arready_d;
      rvalid_q  <= rvalid_d;
      rdata_q   <= rdata_d;
      rresp_q   <= rresp_d;
    end
  end

  assign pin_input_en_o = pin_en_q;
  assign irq_o          = irq_q;
  assign s_axi_awready  = awready_q;
  assign s_axi_wready   = wready_q;
  assign s_axi_bvalid   = bvalid_q;
  assign s_axi_bresp    = bresp_q;
  assign s_axi_arready  = arready_q;
  assign s_axi_rvalid   = rvalid_q;
  assign s_axi_rdata    = rdata_q;
  assign s_axi_rresp    = rresp_q;
endmodule
`default_nettype wire

//--- testbench/ftm_fan_model.sv
// Behavioural fan tach output: square wave, parks low when stopped, optional fast glitches
`default_nettype none
module ftm_fan_model (
  input  wire logic        clk_i,
  input  wire logic        run_i,
  input  wire logic [15:0] half_i,
  input  wire logic        glitch_i,
  output logic             pin_o
);
  timeunit 1ns;
  timeprecision 1ns;
  int cnt;
  initial
  begin
    pin_o = 1'b0;
    cnt   = 0;
  end
  // A stopped fan rests low unless glitch_i toggles it, so a restart never begins with a hidden edge
  always @(posedge clk_i)
  begin
    if (glitch_i)
      pin_o <= ~pin_o;
    else if (!run_i)
    begin
      pin_o <= 1'b0;
      cnt   <= 0;
    end
    else if (cnt + 1 >= int'(half_i))
    begin
      pin_o <= ~pin_o;
      cnt   <= 0;
    end
    else
      cnt <= cnt + 1;
  end
endmodule
`default_nettype wire

//--- testbench/ftm_top_chk.sv
// Port-level assertions of the fan tach monitor
`default_nettype none
module ftm_top_chk (
  input wire logic        clk_i,
  input wire logic        rstn_i,
  input wire logic        pin_input_en_o,
  input wire logic        irq_o,
  input wire logic [31:0] s_axi_awaddr,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0]  s_axi_wstrb,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_bvalid,
  input wire logic [31:0] s_axi_araddr,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0]  s_axi_rresp,
  input wire logic        s_axi_rvalid
);
  logic [31:0] wa_q, wa_d, wd_q, wd_d, ra_q, ra_d;
  logic [3:0]  ws_q, ws_d;
  logic [15:0] ctl_q, ctl_d, spd_q, spd_d;
  logic        bv_q, frz_q, frz_d;

  // Shadow of the writable control bits, taken when a control write is answered
  always_comb
  begin
    wa_d  = (s_axi_awvalid && s_axi_awready) ? s_axi_awaddr : wa_q;
    wd_d  = (s_axi_wvalid && s_axi_wready) ? s_axi_wdata : wd_q;
    ws_d  = (s_axi_wvalid && s_axi_wready) ? s_axi_wstrb : ws_q;
    ra_d  = (s_axi_arvalid && s_axi_arready) ? s_axi_araddr : ra_q;
    ctl_d = ctl_q;
    if (s_axi_bvalid && !bv_q && wa_q == 32'h0 && s_axi_bresp == 2'h0)
      ctl_d = {ws_q[1] ? wd_q[15:8] & 8'hdd : ctl_q[15:8], ws_q[0] ? wd_q[7:0] & 8'h03 : ctl_q[7:0]};
    spd_d = spd_q;
    frz_d = frz_q && !pin_input_en_o;
    if (s_axi_rvalid && ra_q == 32'h0)
    begin
      spd_d = s_axi_rdata[31:16];
      frz_d = !pin_input_en_o;
    end
  end

  always_ff @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
      {wa_q, wd_q, ws_q, ra_q, ctl_q, spd_q, bv_q, frz_q} <= '0;
    else
      {wa_q, wd_q, ws_q, ra_q, ctl_q, spd_q, bv_q, frz_q} <= {wa_d, wd_d, ws_d, ra_d, ctl_d, spd_d, s_axi_bvalid, frz_d};
  end

  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!rstn_i);

  chk_pin_follow_en:
    assert property ($rose(s_axi_bvalid) && wa_q == 32'h0 && s_axi_bresp == 2'h0 && ws_q[0]
      |=> pin_input_en_o == wd_q[1]) else $error("pin enable does not follow control");
  chk_pin_idle_off:
    assert property (!ctl_q[1] && !$past(ctl_q[1]) |-> !pin_input_en_o) else $error("pin enabled while idle");
  chk_irq_gated:
    assert property (irq_o |-> (ctl_q & 16'hc001) != 16'h0 || (ctl_d & 16'hc001) != 16'h0)
      else $error("interrupt without enable");
  chk_ctrl_readback:
    assert property ($rose(s_axi_rvalid) && ra_q == 32'h0 |-> s_axi_rdata[15:0] == ctl_q)
      else $error("control readback wrong");
  chk_ctrl_rsv_zero:
    assert property (s_axi_rvalid && ra_q == 32'h0 |-> (s_axi_rdata & 32'h000022fc) == 32'h0)
      else $error("control reserved bits set");
  chk_status_rsv:
    assert property (s_axi_rvalid && ra_q == 32'h4 |-> s_axi_rdata[31:4] == 28'h0)
      else $error("status reserved bits set");
  chk_unmapped_err:
    assert property (s_axi_rvalid && ra_q > 32'h10 |-> s_axi_rresp == 2'h2 && s_axi_rdata == 32'h0)
      else $error("unmapped read not refused");
  chk_frozen_speed:
    assert property ($rose(s_axi_rvalid) && ra_q == 32'h0 && frz_q |-> s_axi_rdata[31:16] == spd_q)
      else $error("speed moved while disabled");
endmodule

bind ftm_top ftm_top_chk ftm_top_chk_inst (.*);
`default_nettype wire

//--- testbench/ftm_top_tb.sv
// Self-checking bench of the fan tach monitor
`default_nettype none
module ftm_top_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clk_i, rstn_i, fan_pin, pin_d, fan_run, glitch, pin_en, irq;
  logic        awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
  logic [31:0] awaddr, wdata, araddr, rdata;
  logic [3:0]  wstrb;
  logic [1:0]  bresp, rresp;
  logic [15:0] half;
  int          error_cnt, num_checks, rises;

  ftm_top ftm_top_inst (.clk_i(clk_i), .rstn_i(rstn_i), .fan_pulse_pin_i(fan_pin), .pin_input_en_o(pin_en),
    .irq_o(irq), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready));
  ftm_fan_model ftm_fan_model_inst (.clk_i(clk_i), .run_i(fan_run), .half_i(half), .glitch_i(glitch),
    .pin_o(fan_pin));

  initial
  begin
    clk_i = 1'b0;
    forever #50 clk_i = ~clk_i;
  end

  // Independent count of fan rising edges
  always @(posedge clk_i)
  begin
    pin_d <= fan_pin;
    if (fan_pin && !pin_d)
      rises <= rises + 1;
  end

  function automatic int exp_ticks(input logic [1:0] code, input int k);
    int edges[4] = '{2, 3, 5, 9};
    return (edges[code] - 1) * k;
  endfunction

  task automatic summarize();
    $display("checks %0d errors %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  task automatic timeout(input string m);
    error_cnt++;
    $display("ERROR %0t timeout %s", $time, m);
    summarize();
  endtask

  task automatic check(input logic [31:0] got, input logic [31:0] exp, input string m);
    num_checks++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("ERROR %0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge clk_i);
  endtask

  task automatic axw(input logic [31:0] a, input logic [31:0] d, input logic [3:0] s, input logic [1:0] er);
    int n;
    @(posedge clk_i);
    n = 0;
    awaddr <= a;
    wdata <= d;
    wstrb <= s;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do
    begin
      @(posedge clk_i);
      n++;
      if (awvalid && awready)
        awvalid <= 1'b0;
      if (wvalid && wready)
        wvalid <= 1'b0;
    end while (bvalid !== 1'b1 && n < 100);
    bready <= 1'b0;
    if (n >= 100)
      timeout("write");
    check({30'h0, bresp}, {30'h0, er}, "bresp");
  endtask

  task automatic axr(input logic [31:0] a, output logic [31:0] d, output logic [1:0] r);
    int n;
    @(posedge clk_i);
    n = 0;
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do
    begin
      @(posedge clk_i);
      n++;
      if (arvalid && arready)
        arvalid <= 1'b0;
    end while (rvalid !== 1'b1 && n < 100);
    rready <= 1'b0;
    if (n >= 100)
      timeout("read");
    d = rdata;
    r = rresp;
  endtask

  task automatic get_speed(output logic [15:0] s);
    logic [31:0] d;
    logic [1:0]  r;
    axr(32'h0, d, r);
    s = d[31:16];
  endtask

  task automatic chk_speed(input logic [15:0] base, input int n, input string m);
    logic [15:0] s;
    get_speed(s);
    check({16'h0, s - base}, {16'h0, 16'(n)}, m);
  endtask

  task automatic wait_ready();
    logic [31:0] d;
    logic [1:0]  r;
    int          n;
    n = 0;
    do
    begin
      axr(32'h4, d, r);
      n++;
    end while (d[3] !== 1'b1 && n < 1000);
    if (n >= 1000)
      timeout("ready");
  endtask

  initial
  begin
    logic [31:0] d;
    logic [1:0]  r;
    logic [15:0] sp;
    int          k, e;
    {rstn_i, fan_run, glitch, pin_d, awvalid, wvalid, bready, arvalid, rready} = '0;
    {awaddr, wdata, araddr, wstrb} = '0;
    half = 16'h0014;
    {error_cnt, num_checks, rises} = '0;
    void'($urandom(32'h3e3a6730));
    repeat (10) @(posedge clk_i);
    rstn_i <= 1'b1;
    axr(32'h0, d, r);
    check(d, 32'h0, "ctrl reset");
    axw(32'h0, 32'hfffffdfd, 4'hf, 2'h0);
    axr(32'h0, d, r);
    check({16'h0, d[15:0]}, ftm_pkg::CTRL_WMASK & 32'h0000fdfd, "ctrl reserved");
    axw(32'h0, 32'h0, 4'hf, 2'h0);
    axr(32'h14, d, r);
    check({30'h0, r}, 32'h2, "unmapped read");
    axw(32'h20, 32'h1, 4'hf, 2'h2);
    $display("test registers done");
    half <= 16'(10 + $urandom_range(30));
    axw(32'h0, 32'h2, 4'h3, 2'h0);
    cyc(2);
    check({31'h0, pin_en}, 32'h1, "pin enable");
    get_speed(sp);
    k = rises;
    fan_run <= 1'b1;
    cyc(400 + $urandom_range(400));
    fan_run <= 1'b0;
    cyc(10);
    chk_speed(sp, rises - k, "mode0 count");
    $display("test edge count done");
    axw(32'h0, 32'h102, 4'h3, 2'h0);
    get_speed(sp);
    glitch <= 1'b1;
    cyc(4);
    glitch <= 1'b0;
    cyc(400);
    chk_speed(sp, 0, "glitch");
    half <= 16'h012c;
    k = rises;
    fan_run <= 1'b1;
    cyc(3000);
    fan_run <= 1'b0;
    cyc(500);
    chk_speed(sp, rises - k, "filtered");
    $display("test filter done");
    half <= 16'h0014;
    axw(32'h0, 32'h0, 4'h3, 2'h0);
    cyc(2);
    check({31'h0, pin_en}, 32'h0, "pin released");
    get_speed(sp);
    fan_run <= 1'b1;
    cyc(300);
    fan_run <= 1'b0;
    cyc(10);
    chk_speed(sp, 0, "frozen");
    k = rises;
    axw(32'h0, 32'h2, 4'h3, 2'h0);
    fan_run <= 1'b1;
    cyc(300);
    fan_run <= 1'b0;
    cyc(10);
    chk_speed(sp, rises - k, "resumed");
    $display("test enable done");
    for (int c = 0; c < 4; c++)
    begin
      k = 1 + $urandom_range(2);
      e = exp_ticks(c[1:0], k);
      half <= 16'(100 * k);
      axw(32'h0, {19'h0, c[1:0], 11'h402}, 4'h3, 2'h0);
      axw(32'h4, 32'hf, 4'h1, 2'h0);
      fan_run <= 1'b1;
      wait_ready();
      wait_ready();
      get_speed(sp);
      fan_run <= 1'b0;
      check({31'h0, 32'(sp) + 1 >= e && 32'(sp) <= e + 1}, 32'h1, "mode1 count");
    end
    $display("test reference count done");
    half <= 16'h00c8;
    axw(32'h8, 32'h0, 4'h3, 2'h0);
    axw(32'h0, 32'h402, 4'h3, 2'h0);
    fan_run <= 1'b1;
    cyc(1000);
    fan_run <= 1'b0;
    cyc(50);
    check({31'h0, irq}, 32'h0, "irq disabled");
    axw(32'h0, 32'h403, 4'h3, 2'h0);
    cyc(3);
    check({31'h0, irq}, 32'h1, "irq enabled");
    axw(32'h10, 32'h0, 4'h1, 2'h0);
    cyc(3);
    check({31'h0, irq}, 32'h0, "irq masked");
    axw(32'h10, 32'h1, 4'h1, 2'h0);
    cyc(3);
    check({31'h0, irq}, 32'h1, "irq unmasked");
    axw(32'h4, 32'h1, 4'h1, 2'h0);
    cyc(3);
    check({31'h0, irq}, 32'h0, "flag cleared");
    $display("test limit done");
    summarize();
  end
endmodule
`default_nettype wire
